// ### hdl/conv_pkg.sv
// Constants and the phase type of the converter sequencer.
// Assumes a single 40 MHz clock and an APB register interface.
package conv_pkg;

  // ---------------------------------------------
  // Timing
  // ---------------------------------------------
  localparam int CLK_HZ = 40_000_000; // Bus clock rate
  localparam int CONV_TIME_MS = 50; // One conversion
  localparam int ADV_TIME_MS = 320; // Clock wheels moving
  localparam int MINUTE_TIME_S = 60; // One clock step
  localparam int unsigned CONV_CYCLES = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned ADV_CYCLES = ADV_TIME_MS * (CLK_HZ / 1000);
  localparam longint unsigned MINUTE_CYCLES = longint'(MINUTE_TIME_S) * CLK_HZ;

  // ---------------------------------------------
  // Register offsets and fields
  // ---------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00; // Command, write only
  localparam logic [7:0] REG_SEL = 8'h04; // Point selector
  localparam logic [7:0] REG_STAT = 8'h08; // Status
  localparam logic [7:0] REG_RESULT = 8'h0c; // Result register
  localparam logic [7:0] REG_XFER = 8'h10; // Last stored word
  localparam logic [7:0] REG_CLOCK = 8'h14; // Time of day
  localparam logic [7:0] REG_CTRL = 8'h18; // Control
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_NEG = 2;
  localparam int STAT_OVL = 3;
  localparam int STAT_CLK_BLOCK = 4;
  localparam int STAT_CLK_PEND = 5;
  localparam int CTRL_CLR_DONE = 0; // Write 1 clears done
  localparam int CTRL_IRQ_EN = 1; // Done request enable
  localparam int RES_NEG = 16; // Sign flag in result view
  localparam int RES_OVL = 17; // Overload flag in result view

  // ---------------------------------------------
  // Commands, classes, codes, resets
  // ---------------------------------------------
  localparam logic [2:0] CMD_CONVERT = 3'h1;
  localparam logic [2:0] CMD_READ_CONVERT = 3'h2;
  localparam logic [2:0] CMD_SEL_READ = 3'h3;
  localparam logic [2:0] CMD_CLOCK_READ = 3'h4;
  localparam logic [2:0] CMD_SCAN_STEP = 3'h5;
  localparam logic [1:0] CLS_MUX = 2'h0; // Analog in/out, contact operate
  localparam logic [1:0] CLS_HSCS = 2'h1; // High-speed contact sense
  localparam logic [1:0] CLS_OPU = 2'h2; // Operator units
  localparam logic [11:0] MUX_MAX = 12'h299;
  localparam logic [11:0] HSCS_MAX = 12'h019;
  localparam logic [11:0] OPU_MAX = 12'h099;
  localparam logic [3:0] OVL_82 = 4'ha; // Bits 8-2
  localparam logic [3:0] OVL_821 = 4'hb; // Bits 8-2-1
  localparam logic [1:0] XK_RESULT = 2'h0;
  localparam logic [1:0] XK_SELECTOR = 2'h1;
  localparam logic [1:0] XK_CLOCK = 2'h2;
  localparam logic [13:0] SEL_RESET = 14'h0000;
  localparam logic [15:0] TOD_RESET = 16'h0000;

  // ---------------------------------------------
  // Types
  // ---------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_CONV = 3'b100
  } seq_state_t;

endpackage

// ### hdl/tod_if.sv
// Time-of-day link between clock keeper and sequencer.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
`default_nettype none
interface tod_if;
  logic [15:0] digits; // Hours tens, units, tenths, hundredths
  logic blocked; // Wheels advancing, no read-out
  modport keeper (output digits, output blocked);
  modport user (input digits, input blocked);
endinterface
`default_nettype wire

// ### hdl/tod_clock.sv
// Twenty-four hour time-of-day keeper in BCD hours.
// Assumes the minute and advance lengths given by the parent.
`timescale 1ns/1ps
`default_nettype none
module tod_clock #(
  parameter longint unsigned MIN_CYC = conv_pkg::MINUTE_CYCLES,
  parameter int unsigned ADV_CYC = conv_pkg::ADV_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  tod_if.keeper tod
);

  typedef struct packed {
    logic [31:0] min_cnt; // Cycles into the minute
    logic [23:0] adv_cnt; // Cycles into the advance
    logic adv; // Wheels moving
    logic [15:0] dig; // Displayed time
  } tod_state_t;

  tod_state_t s_r, s_nxt;

  // ---------------------------------------------
  // Next time after one step
  // ---------------------------------------------
  function automatic logic [15:0] step(input logic [15:0] d);
    logic [15:0] n;
    n = d;
    case (d[3:0]) // Low wheel 0-2-3-5-7-8-0
      4'h0: n[3:0] = 4'h2;
      4'h2: n[3:0] = 4'h3;
      4'h3: n[3:0] = 4'h5;
      4'h5: n[3:0] = 4'h7;
      4'h7: n[3:0] = 4'h8;
      default: begin
        n[3:0] = 4'h0;
        if (d[7:4] == 4'h9) begin
          n[7:4] = 4'h0;
          if (d[15:8] == 8'h23) begin
            n[15:8] = 8'h00;
          end else if (d[11:8] == 4'h9) begin
            n[11:8] = 4'h0;
            n[15:12] = d[15:12] + 4'h1;
          end else begin
            n[11:8] = d[11:8] + 4'h1;
          end
        end else begin
          n[7:4] = d[7:4] + 4'h1;
        end
      end
    endcase
    return n;
  endfunction

  // Minute timing and wheel advance
  always_comb begin
    s_nxt = s_r;
    if (s_r.min_cnt == 32'(MIN_CYC - 1)) begin
      s_nxt.min_cnt = 32'h0;
      s_nxt.adv = 1'b1;
      s_nxt.adv_cnt = 24'h0;
    end else begin
      s_nxt.min_cnt = s_r.min_cnt + 32'h1;
    end
    if (s_r.adv) begin
      if (s_r.adv_cnt == 24'(ADV_CYC - 1)) begin
        s_nxt.adv = 1'b0;
        s_nxt.dig = step(s_r.dig);
      end else begin
        s_nxt.adv_cnt = s_r.adv_cnt + 24'h1;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{min_cnt: 32'h0, adv_cnt: 24'h0, adv: 1'b0, dig: conv_pkg::TOD_RESET};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tod.digits = s_r.dig;
  assign tod.blocked = s_r.adv;

endmodule
`default_nettype wire

// ### hdl/conv_seq.sv
// Converter sequencer: point selection, timed conversion, result
// transfers and time-of-day read-out, reached over APB.
// Assumes the analog front end converts while mux_connect is high and
// presents sign and BCD digits on pins, stable at conversion end.
//
// Behaviour
// - Each conversion lasts fifty milliseconds.
// - Result 0000-9999 held until transferred.
// - Sign comes from the conversion itself.
// - Negative flags units digit, lights sign lamp.
// - Overload keeps 8-2 or 8-2-1 high digit.
// - Overload transfer stores four flag bits.
// - Result transfer flags the high digit.
// - Only the selected point reaches converter.
// - Convert command connects point, no transfer.
// - Read-convert transfers first, then converts.
// - Busy stays set throughout each conversion.
// - Multiplexer instructions stall while busy.
// - Conversion end sets done, raises request.
// - Clock counts 00.00 to 23.98, readable.
// - Low clock digit steps 0-2-3-5-7-8.
// - Clock read-out blocked while wheels advance.
// - Three-digit selector, ranges per point class.
// - Selector read stores the three selector digits, not the class.
// - Only multiplexer classes convert or stall.
// - Done request only when option fitted.
`timescale 1ns/1ps
`default_nettype none
module conv_seq #(
  parameter int unsigned CONV_CYC = conv_pkg::CONV_CYCLES,
  parameter int unsigned ADV_CYC = conv_pkg::ADV_CYCLES,
  parameter longint unsigned MIN_CYC = conv_pkg::MINUTE_CYCLES,
  parameter bit IRQ_FITTED = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adc_negative,
  input wire logic [15:0] adc_digits,
  output logic [11:0] mux_point,
  output logic mux_connect,
  input wire logic mux_instr_req,
  output logic mux_instr_stall,
  output logic conv_busy,
  output logic conv_done,
  output logic done_irq,
  output logic neg_lamp,
  output logic core_wr_stb,
  output logic [19:0] core_wr_data,
  output logic [1:0] core_wr_kind
);

  // ---------------------------------------------
  // State record
  // ---------------------------------------------
  typedef struct packed {
    conv_pkg::seq_state_t st; // Sequencer phase
    logic [23:0] conv_cnt; // Cycles into conversion
    logic busy; // Conversion running
    logic done; // Conversion finished
    logic irq_en; // Done request enable
    logic [15:0] res; // Result digits
    logic res_neg; // Negative flag
    logic res_ovl; // Overload flag
    logic [13:0] sel; // Class and three digits
    logic [11:0] conv_point; // Point being converted
    logic clk_pend; // Clock read waiting
    logic [19:0] xfer; // Last stored word
    logic [1:0] xkind; // Source of that word
    logic xstb; // Store pulse
    logic [16:0] pin_s1; // Pin sync, first stage
    logic [16:0] pin_s2; // Pin sync, second stage
    logic [31:0] rdata; // Read data for access
    logic err; // Unmapped address
  } conv_state_t;

  conv_state_t s_r, s_nxt;
  tod_if tod ();

  // ---------------------------------------------
  // Time-of-day keeper
  // ---------------------------------------------
  tod_clock #(
    .MIN_CYC(MIN_CYC),
    .ADV_CYC(ADV_CYC)
  ) u_tod (
    .pclk(pclk),
    .presetn(presetn),
    .tod(tod)
  );

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  // Highest address of a point class
  function automatic logic [11:0] class_max(input logic [1:0] cls);
    case (cls)
      conv_pkg::CLS_MUX: return conv_pkg::MUX_MAX;
      conv_pkg::CLS_HSCS: return conv_pkg::HSCS_MAX;
      conv_pkg::CLS_OPU: return conv_pkg::OPU_MAX;
      default: return 12'h000;
    endcase
  endfunction

  // Valid three-digit BCD address within its class
  function automatic logic sel_ok(input logic [13:0] v);
    logic ok;
    ok = (v[11:8] <= 4'h9) && (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
    return ok && (v[13:12] != 2'h3) && (v[11:0] <= class_max(v[13:12]));
  endfunction

  // Scanning counter step, wrapping past the class top
  function automatic logic [11:0] scan_next(input logic [13:0] v);
    logic [11:0] n;
    n = v[11:0];
    if (v[11:0] >= class_max(v[13:12])) begin
      n = 12'h000;
    end else if (v[3:0] != 4'h9) begin
      n[3:0] = v[3:0] + 4'h1;
    end else if (v[7:4] != 4'h9) begin
      n[3:0] = 4'h0;
      n[7:4] = v[7:4] + 4'h1;
    end else begin
      n[7:0] = 8'h00;
      n[11:8] = v[11:8] + 4'h1;
    end
    return n;
  endfunction

  // Register read mux
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input conv_state_t s,
                                         input logic blk, input logic [15:0] t);
    logic [31:0] d;
    d = 32'h0;
    case (a)
      conv_pkg::REG_SEL: d[13:0] = s.sel;
      conv_pkg::REG_STAT: begin
        d[conv_pkg::STAT_BUSY] = s.busy;
        d[conv_pkg::STAT_DONE] = s.done;
        d[conv_pkg::STAT_NEG] = s.res_neg;
        d[conv_pkg::STAT_OVL] = s.res_ovl;
        d[conv_pkg::STAT_CLK_BLOCK] = blk;
        d[conv_pkg::STAT_CLK_PEND] = s.clk_pend;
      end
      conv_pkg::REG_RESULT: begin
        d[15:0] = s.res;
        d[conv_pkg::RES_NEG] = s.res_neg;
        d[conv_pkg::RES_OVL] = s.res_ovl;
      end
      conv_pkg::REG_XFER: d[21:0] = {s.xkind, s.xfer};
      conv_pkg::REG_CLOCK: d[15:0] = t;
      conv_pkg::REG_CTRL: d[conv_pkg::CTRL_IRQ_EN] = s.irq_en;
      default: d = 32'h0;
    endcase
    return d;
  endfunction

  // Word stored for a result transfer
  function automatic logic [19:0] result_word(input conv_state_t s);
    if (s.res_ovl) begin
      return {4{5'b1_0000}};
    end
    // High digit flagged, units digit carries sign
    return {1'b1, s.res[15:12], 1'b0, s.res[11:8],
            1'b0, s.res[7:4], s.res_neg, s.res[3:0]};
  endfunction

  // ---------------------------------------------
  // Bus decode
  // ---------------------------------------------
  logic setup; // First cycle of a transfer
  logic wr_acc; // Write taking effect
  logic mapped; // Address decodes
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && !s_r.err;
  always_comb begin
    case (paddr)
      conv_pkg::REG_CMD, conv_pkg::REG_SEL, conv_pkg::REG_STAT,
      conv_pkg::REG_RESULT, conv_pkg::REG_XFER, conv_pkg::REG_CLOCK,
      conv_pkg::REG_CTRL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ---------------------------------------------
  // Sequencer
  // ---------------------------------------------
  always_comb begin
    logic [2:0] cmd;
    logic launch;
    cmd = pwdata[2:0];
    launch = 1'b0;
    s_nxt = s_r;
    s_nxt.xstb = 1'b0;
    // Pins pass two flops before use
    s_nxt.pin_s1 = {adc_negative, adc_digits};
    s_nxt.pin_s2 = s_r.pin_s1;
    // Read data caught in setup, answered in access
    if (setup) begin
      s_nxt.rdata = rd_mux(paddr, s_r, tod.blocked, tod.digits);
      s_nxt.err = !mapped;
    end
    // Register writes
    if (wr_acc) begin
      case (paddr)
        conv_pkg::REG_CMD: begin
          case (cmd)
            conv_pkg::CMD_CONVERT, conv_pkg::CMD_READ_CONVERT: begin
              // Only idle multiplexer points convert
              if (!s_r.busy && s_r.sel[13:12] == conv_pkg::CLS_MUX) begin
                launch = 1'b1;
                s_nxt.busy = 1'b1;
                s_nxt.done = 1'b0;
                s_nxt.conv_point = s_r.sel[11:0];
                if (cmd == conv_pkg::CMD_READ_CONVERT) begin
                  s_nxt.xfer = result_word(s_r);
                end
                s_nxt.st = (cmd == conv_pkg::CMD_CONVERT) ?
                           conv_pkg::ST_CONV : conv_pkg::ST_XFER;
              end
            end
            conv_pkg::CMD_SEL_READ: begin
              s_nxt.xfer = {8'h00, s_r.sel[11:0]};
              s_nxt.xkind = conv_pkg::XK_SELECTOR;
              s_nxt.xstb = 1'b1;
            end
            conv_pkg::CMD_CLOCK_READ: s_nxt.clk_pend = 1'b1;
            conv_pkg::CMD_SCAN_STEP: s_nxt.sel[11:0] = scan_next(s_r.sel);
            default: s_nxt.st = s_r.st;
          endcase
        end
        conv_pkg::REG_SEL: begin
          // Out-of-range addresses are dropped
          if (sel_ok(pwdata[13:0])) begin
            s_nxt.sel = pwdata[13:0];
          end
        end
        conv_pkg::REG_CTRL: begin
          s_nxt.irq_en = pwdata[conv_pkg::CTRL_IRQ_EN];
          if (pwdata[conv_pkg::CTRL_CLR_DONE]) begin
            s_nxt.done = 1'b0;
          end
        end
        default: s_nxt.irq_en = s_r.irq_en;
      endcase
    end
    // Fresh conversion drops old flags
    if (launch) begin
      s_nxt.res_neg = 1'b0;
      s_nxt.res_ovl = 1'b0;
      s_nxt.conv_cnt = 24'h0;
    end
    // Conversion phases
    case (s_r.st)
      conv_pkg::ST_IDLE: s_nxt.conv_cnt = s_nxt.conv_cnt;
      conv_pkg::ST_XFER: begin
        // Word caught at launch, before the flags dropped
        s_nxt.xkind = conv_pkg::XK_RESULT;
        s_nxt.xstb = 1'b1;
        s_nxt.st = conv_pkg::ST_CONV;
      end
      conv_pkg::ST_CONV: begin
        if (s_r.conv_cnt == 24'(CONV_CYC - 1)) begin
          s_nxt.st = conv_pkg::ST_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.res = s_r.pin_s2[15:0];
          s_nxt.res_neg = s_r.pin_s2[16];
          s_nxt.res_ovl = (s_r.pin_s2[15:12] == conv_pkg::OVL_82) ||
                          (s_r.pin_s2[15:12] == conv_pkg::OVL_821);
        end else begin
          s_nxt.conv_cnt = s_r.conv_cnt + 24'h1;
        end
      end
      default: s_nxt.st = conv_pkg::ST_IDLE;
    endcase
    // Clock read waits out the advance and other stores
    if (s_r.clk_pend && !tod.blocked && !s_nxt.xstb &&
        (s_nxt.st != conv_pkg::ST_XFER)) begin
      s_nxt.xfer = {4'h0, tod.digits};
      s_nxt.xkind = conv_pkg::XK_CLOCK;
      s_nxt.xstb = 1'b1;
      s_nxt.clk_pend = 1'b0;
    end
  end

  // ---------------------------------------------
  // State register
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{st: conv_pkg::ST_IDLE, sel: conv_pkg::SEL_RESET, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  assign prdata = s_r.rdata;
  assign pready = 1'b1; // Zero-wait access
  assign pslverr = psel && penable && s_r.err;
  assign mux_point = s_r.conv_point;
  assign mux_connect = (s_r.st == conv_pkg::ST_CONV);
  assign conv_busy = s_r.busy;
  assign conv_done = s_r.done;
  assign done_irq = IRQ_FITTED && s_r.irq_en && s_r.done;
  assign neg_lamp = s_r.res_neg;
  // Stall multiplexer users, others bypass
  assign mux_instr_stall = mux_instr_req && s_r.busy &&
                           (s_r.sel[13:12] == conv_pkg::CLS_MUX);
  assign core_wr_stb = s_r.xstb;
  assign core_wr_data = s_r.xfer;
  assign core_wr_kind = s_r.xkind;

endmodule
`default_nettype wire

// ### bench/conv_seq_monitor.sv
// Port checker of the converter sequencer, bound to its top.
// Assumes the conversion length handed down from the design.
`timescale 1ns/1ps
`default_nettype none
module conv_seq_monitor #(
  parameter int unsigned CONV_CYC = conv_pkg::CONV_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mux_instr_req,
  input wire logic adc_negative,
  input wire logic [11:0] mux_point,
  input wire logic mux_connect,
  input wire logic mux_instr_stall,
  input wire logic conv_busy,
  input wire logic conv_done,
  input wire logic done_irq,
  input wire logic neg_lamp,
  input wire logic core_wr_stb,
  input wire logic [19:0] core_wr_data,
  input wire logic [1:0] core_wr_kind
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] conn_cnt_r; // Connected cycles so far
  // ---------------------------------------------
  // Length of the connected stretch
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) conn_cnt_r <= 32'h0;
    else if (mux_connect) conn_cnt_r <= conn_cnt_r + 32'h1;
    else conn_cnt_r <= 32'h0;
  end
  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  AST_CONV_LEN: assert property ($fell(mux_connect) |-> conn_cnt_r == CONV_CYC)
    else $error("conversion length wrong");
  AST_DONE_ENDS: assert property ($rose(conv_done) |-> $fell(conv_busy) && $fell(mux_connect))
    else $error("done not at conversion end");
  AST_CONNECT_BUSY: assert property (mux_connect |-> conv_busy)
    else $error("connected while not busy");
  AST_STALL: assert property (mux_instr_stall |-> mux_instr_req && conv_busy)
    else $error("stall without cause");
  AST_NEG_LAMP: assert property ($rose(conv_done) |-> neg_lamp == adc_negative)
    else $error("sign lamp wrong");
  AST_LAUNCH_CLR: assert property ($rose(conv_busy) |-> !neg_lamp && !conv_done)
    else $error("flags not cleared at launch");
  AST_RD_CONV: assert property ($rose(conv_busy) && !mux_connect |->
    ##1 core_wr_stb && core_wr_kind == conv_pkg::XK_RESULT && mux_connect)
    else $error("read then convert order wrong");
  AST_CONV_ONLY: assert property ($rose(conv_busy) && mux_connect |-> !core_wr_stb)
    else $error("convert stored a word");
  AST_HIGH_FLAG: assert property (core_wr_stb && core_wr_kind == 2'h0 |-> core_wr_data[19])
    else $error("high digit not flagged");
  AST_IRQ: assert property (done_irq |-> conv_done)
    else $error("request without done");
  AST_POINT_HOLD: assert property (mux_connect && $past(mux_connect) |-> $stable(mux_point))
    else $error("point moved while connected");
endmodule
bind conv_seq conv_seq_monitor #(.CONV_CYC(CONV_CYC)) u_conv_seq_monitor (
  .pclk(pclk), .presetn(presetn), .mux_instr_req(mux_instr_req),
  .adc_negative(adc_negative), .mux_point(mux_point), .mux_connect(mux_connect),
  .mux_instr_stall(mux_instr_stall), .conv_busy(conv_busy), .conv_done(conv_done),
  .done_irq(done_irq), .neg_lamp(neg_lamp), .core_wr_stb(core_wr_stb),
  .core_wr_data(core_wr_data), .core_wr_kind(core_wr_kind)
);
`default_nettype wire

// ### bench/adc_front_model.sv
// Analog front end model answering the selected point.
// Assumes BCD point codes and the sequencer's connect level.
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] mux_point,
  input wire logic mux_connect,
  output logic adc_negative,
  output logic [15:0] adc_digits
);
  // Odd points read negative, two points overload
  function automatic logic [16:0] reading(input logic [11:0] p);
    if (p == 12'h299) return {p[0], 4'ha, 12'h123};
    if (p == 12'h298) return {p[0], 4'hb, 12'h456};
    return {p[0], 4'h1, p};
  endfunction
  // Only the connected point drives; otherwise toggle so stale data never matches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {adc_negative, adc_digits} <= 17'h0;
    else if (mux_connect) {adc_negative, adc_digits} <= reading(mux_point);
    else {adc_negative, adc_digits} <= ~{adc_negative, adc_digits};
  end
endmodule
`default_nettype wire

// ### bench/conv_seq_test.sv
// Self-checking bench of the converter sequencer over APB.
// Assumes shortened conversion, advance and minute lengths.
`timescale 1ns/1ps
`default_nettype none
module conv_seq_test;
  // ---------------------------------------------
  // Signals
  // ---------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic mux_instr_req = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, adc_negative, mux_connect, mux_instr_stall;
  logic conv_busy, conv_done, done_irq, neg_lamp, core_wr_stb;
  logic [15:0] adc_digits;
  logic [11:0] mux_point;
  logic [19:0] core_wr_data;
  logic [1:0] core_wr_kind;
  logic [19:0] last_word = 20'h0; // Last word stored to core
  logic [1:0] last_kind = 2'h0; // Its kind
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0; // Timeout count
  logic [15:0] tod [6] = '{16'h2, 16'h3, 16'h5, 16'h7, 16'h8, 16'h10};
  logic [31:0] sel_w [7] = '{32'h123, 32'h12a, 32'h300, 32'h3001, 32'h1020, 32'h1019, 32'h2099};
  logic [31:0] sel_e [7] = '{32'h123, 32'h123, 32'h123, 32'h123, 32'h123, 32'h1019, 32'h2099};
  // ---------------------------------------------
  // Design, front end, clock
  // ---------------------------------------------
  conv_seq #(.CONV_CYC(20), .ADV_CYC(5), .MIN_CYC(40)) u_conv_seq (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_negative(adc_negative),
    .adc_digits(adc_digits), .mux_point(mux_point), .mux_connect(mux_connect),
    .mux_instr_req(mux_instr_req), .mux_instr_stall(mux_instr_stall),
    .conv_busy(conv_busy), .conv_done(conv_done), .done_irq(done_irq),
    .neg_lamp(neg_lamp), .core_wr_stb(core_wr_stb),
    .core_wr_data(core_wr_data), .core_wr_kind(core_wr_kind)
  );
  adc_front_model u_adc_front_model (
    .pclk(pclk), .presetn(presetn), .mux_point(mux_point),
    .mux_connect(mux_connect), .adc_negative(adc_negative), .adc_digits(adc_digits)
  );
  always #12.5 pclk = ~pclk;
  // Catch each stored word mid-cycle
  always @(negedge pclk) begin
    if (core_wr_stb === 1'b1) begin
      last_word <= core_wr_data;
      last_kind <= core_wr_kind;
    end
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  // Read and compare; clock status bits masked off
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    chk(a == conv_pkg::REG_STAT ? q & 32'hf : q, exp);
  endtask
  task automatic wait_done;
    logic [31:0] q;
    for (int i = 0; i < 60; i++) begin
      rd(conv_pkg::REG_STAT, q);
      if (q[1] === 1'b1) break;
    end
  endtask
  task automatic conv(input logic [31:0] s, input logic [2:0] c);
    wr(conv_pkg::REG_SEL, s);
    wr(conv_pkg::REG_CMD, {29'h0, c});
    wait_done();
  endtask
  // Stored result word: high digit flagged, sign on units
  function automatic logic [31:0] word(input logic [15:0] d, input logic n);
    return {12'h0, 1'b1, d[15:12], 1'b0, d[11:8], 1'b0, d[7:4], n, d[3:0]};
  endfunction
  // ---------------------------------------------
  // Tests
  // ---------------------------------------------
  initial begin
    logic [31:0] q;
    logic e;
    logic blk;
    int k;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rc(conv_pkg::REG_CLOCK, 32'h0);
    rc(conv_pkg::REG_STAT, 32'h0);
    rc(conv_pkg::REG_SEL, 32'h0);
    apb(1'b0, 8'h1c, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    $display("reset test done");
    // Clock steps, read request while wheels move
    blk = 1'b0;
    k = 0;
    for (int i = 0; i < 300 && k < 6; i++) begin
      rd(conv_pkg::REG_STAT, q);
      if (q[4] === 1'b1) begin
        if (!blk) wr(conv_pkg::REG_CMD, {29'h0, conv_pkg::CMD_CLOCK_READ});
        blk = 1'b1;
      end else if (blk) begin
        blk = 1'b0;
        rc(conv_pkg::REG_CLOCK, {16'h0, tod[k]});
        k++;
      end
    end
    chk(k, 32'h6);
    chk({30'h0, last_kind}, {30'h0, conv_pkg::XK_CLOCK});
    $display("clock test done");
    // Selector ranges and scan wrap
    for (int i = 0; i < 7; i++) begin
      wr(conv_pkg::REG_SEL, sel_w[i]);
      rc(conv_pkg::REG_SEL, sel_e[i]);
    end
    conv(32'h298, conv_pkg::CMD_SCAN_STEP);
    rc(conv_pkg::REG_SEL, 32'h299);
    wr(conv_pkg::REG_CMD, {29'h0, conv_pkg::CMD_SCAN_STEP});
    rc(conv_pkg::REG_SEL, 32'h0);
    $display("selector test done");
    // Convert with a pending multiplexer instruction
    wr(conv_pkg::REG_SEL, 32'h123);
    mux_instr_req <= 1'b1;
    wr(conv_pkg::REG_CMD, {29'h0, conv_pkg::CMD_CONVERT});
    @(negedge pclk);
    chk({20'h0, mux_point}, 32'h123);
    chk({31'h0, mux_instr_stall}, 32'h1);
    @(posedge pclk);
    wr(conv_pkg::REG_SEL, 32'h1005);
    @(negedge pclk);
    chk({31'h0, mux_instr_stall}, 32'h0);
    @(posedge pclk);
    mux_instr_req <= 1'b0;
    wait_done();
    rc(conv_pkg::REG_RESULT, 32'h11123);
    rc(conv_pkg::REG_STAT, 32'h6);
    // Another point next, so no repeat-reading spacing is owed
    conv(32'h124, conv_pkg::CMD_READ_CONVERT);
    rc(conv_pkg::REG_XFER, word(16'h1123, 1'b1));
    rc(conv_pkg::REG_RESULT, 32'h1124);
    $display("convert test done");
    // Overload codes and their stored flags
    conv(32'h299, conv_pkg::CMD_CONVERT);
    rc(conv_pkg::REG_RESULT, 32'h3a123);
    conv(32'h298, conv_pkg::CMD_CONVERT);
    rc(conv_pkg::REG_RESULT, 32'h2b456);
    conv(32'h123, conv_pkg::CMD_READ_CONVERT);
    chk({12'h0, last_word}, 32'h84210);
    $display("overload test done");
    // Done request, its enable and clear
    wr(conv_pkg::REG_CTRL, 32'h2);
    chk({31'h0, done_irq}, 32'h1);
    wr(conv_pkg::REG_CTRL, 32'h3);
    rc(conv_pkg::REG_CTRL, 32'h2);
    rc(conv_pkg::REG_STAT, 32'h4);
    chk({31'h0, done_irq}, 32'h0);
    // Selector store, convert refused off the multiplexer
    wr(conv_pkg::REG_SEL, 32'h2045);
    wr(conv_pkg::REG_CMD, {29'h0, conv_pkg::CMD_SEL_READ});
    chk({30'h0, last_kind}, {30'h0, conv_pkg::XK_SELECTOR});
    chk({12'h0, last_word}, 32'h00045);
    wr(conv_pkg::REG_CMD, {29'h0, conv_pkg::CMD_CONVERT});
    rc(conv_pkg::REG_STAT, 32'h4);
    $display("control test done");
    print_verdict();
  end
endmodule
`default_nettype wire
